// File: hdl/emt_config_regs.sv
// emt_config_regs: apb register bank for sdram refresh and timing and
// the four async region configs, plus the refresh request timer.
// assumes one clock shared with the memory controllers it steers.
//
// Functional notes
// - 13-bit refresh period, resets to 4E2h
// - write below 20h loads 2*rfc+1
// - four async region config registers
// - new config used by following transfers
// - bit 31 selects select-strobe mode
// - bit 30 enables extended wait
// - bits 29:26 write setup minus one
// - bits 25:20 write strobe minus one
// - bits 19:17 write hold minus one
// - bits 16:13 read setup minus one
// - bits 12:7 read strobe minus one
// - bits 6:4 read hold minus one
// - bits 3:2 turnaround minimum minus one
// - bits 1:0 async bus width code
// - sdram timing fields reset values
// - reserved bits read zero
// - refresh-to-refresh minimum minus one
// - precharge minimum minus one
`timescale 1ns/10ps
module emt_config_regs
   import emt_pkg::*;
#(
   parameter int ADDR_W = 8            // apb address width
) (
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   // apb slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [ADDR_W-1:0]      paddr,
   input  wire logic [31:0]            pwdata,
   output logic                        pready,
   output logic                        pslverr,
   output logic [31:0]                 prdata,
   // sdram refresh
   output logic [12:0]                 refresh_period,
   output logic                        refresh_req,
   // sdram command timing
   output logic [4:0]                  refresh_to_refresh_min,
   output logic [2:0]                  precharge_min,
   output logic [2:0]                  activate_to_access_min,
   output logic [2:0]                  write_recovery_min,
   output logic [3:0]                  activate_to_precharge_min,
   output logic [3:0]                  activate_to_activate_min,
   output logic [2:0]                  bank_to_bank_activate_min,
   // async regions, index 0 is region 2
   output logic [3:0]                  select_strobe_mode,
   output logic [3:0]                  extended_wait_enable,
   output logic [3:0][3:0]             write_setup,
   output logic [3:0][5:0]             write_strobe,
   output logic [3:0][2:0]             write_hold,
   output logic [3:0][3:0]             read_setup,
   output logic [3:0][5:0]             read_strobe,
   output logic [3:0][2:0]             read_hold,
   output logic [3:0][1:0]             turnaround_min,
   output logic [3:0][1:0]             async_bus_width
);

   emt_state_t st_r;                   // registered state
   emt_state_t st_nxt;                 // next state

   // decode terms
   logic       acc;                    // apb access phase
   logic       wr_en;                  // write takes effect now
   logic       hit_rrc;                // refresh control hit
   logic       hit_tim;                // timing hit
   logic       hit_cfg;                // any region hit
   logic [1:0] cfg_idx;                // region index
   logic       mapped;                 // any register hit
   logic [7:0] a8;                     // low address byte
   logic [7:0] cfg_off;                // offset into region block
   logic [12:0] rr_new;                // value loaded into period

   // register map, one aligned 32-bit word each:
   //   0x00  refresh rate control
   //   0x04  async region 2 config
   //   0x08  async region 3 config
   //   0x0c  async region 4 config
   //   0x10  async region 5 config
   //   0x14  sdram command timing
   //   any other word answers pslverr, stores nothing
   //   and reads back zero
   //
   // refresh rate control layout:
   //   31:13 reserved, read as zero, writes dropped
   //   12:0  refresh period in memory clock cycles
   //   a write below 0x20 is not taken as written:
   //   the period becomes twice the refresh to
   //   refresh minimum plus one, from the timing
   //   value held before the write
   //
   // async region config layout, all fields r/w:
   //   31    select strobe mode, 0 normal
   //   30    extended wait enable
   //   29:26 write setup, cycles minus one
   //   25:20 write strobe, cycles minus one
   //   19:17 write hold, cycles minus one
   //   16:13 read setup, cycles minus one
   //   12:7  read strobe, cycles minus one
   //   6:4   read hold, cycles minus one
   //   3:2   turnaround minimum, cycles minus one
   //   1:0   bus width: 0 byte, 1 halfword, 2-3 reserved
   //   reset word: slowest timing, 8-bit bus
   //   index 0 of each output array is region 2
   //   fields leave as slices, no decoding applied
   //
   // sdram command timing layout, cycles minus one:
   //   31:27 refresh to refresh
   //   26:24 precharge to activate or refresh
   //   23    reserved
   //   22:20 activate to access
   //   19    reserved
   //   18:16 write recovery
   //   15:12 activate to precharge
   //   11:8  activate to activate
   //   7     reserved
   //   6:4   bank to bank activate
   //   3:0   reserved
   //   reserved bits masked on write, read as zero
   //
   // timing as seen from the apb side:
   //   setup edge: read word captured into prdata
   //   access edge: write lands, pready always high
   //   next cycle: outputs show the new value
   //   no shadow copy: a controller that samples its
   //   settings at access start sees a write made
   //   one cycle earlier; the price is no atomic
   //   update of fields spread over two registers
   //
   // refresh timer:
   //   down counter, reloaded with period minus one
   //   on reaching zero, one request pulse per period
   //   a period write restarts the count at once, so
   //   a shorter period never waits out the old one
   //   limitation: period 1 asks every cycle
   //   first request after reset comes one period
   //   plus one cycle after release, as the counter
   //   starts at the reset period rather than minus one
   //
   // software duties, not enforced here:
   //   keep extended wait off without a wait pin
   //   keep extended wait off for nand regions
   //   write zero to reserved bits
   //   do not pick width codes 2 or 3
   //   write the timing word before a short period
   //   so the period is derived from the right value

   // zero-wait slave, so pready is tied high by design
   assign pready = 1'b1;
   assign acc    = psel & penable;
   assign a8     = 8'(paddr);
   assign cfg_off = a8 - EMT_OFS_CFG2;

   // address decode; upper address bits must be zero
   always_comb begin
      hit_rrc = (paddr == ADDR_W'(EMT_OFS_RRC));
      hit_tim = (paddr == ADDR_W'(EMT_OFS_TIM));
      hit_cfg = (paddr >= ADDR_W'(EMT_OFS_CFG2))
              & (paddr <= ADDR_W'(EMT_OFS_CFG5))
              & (paddr[1:0] == 2'b00);
      cfg_idx = cfg_off[3:2];
      mapped  = hit_rrc | hit_tim | hit_cfg;
   end

   // unmapped access answers with an error, nothing stored
   assign pslverr = acc & ~mapped;
   assign wr_en   = acc & pwrite & mapped;

   // small periods are replaced by the rfc based minimum
   always_comb begin
      if (pwdata[12:0] < EMT_RR_MIN) begin
         rr_new = 13'({st_r.tim[31:27], 1'b1});
      end else begin
         rr_new = pwdata[12:0];
      end
   end

   // next state: bus writes, read capture and refresh timer
   always_comb begin
      st_nxt     = st_r;
      st_nxt.req = 1'b0;
      // refresh timer: period of rr cycles between requests
      if (st_r.cnt == 13'h0000) begin
         st_nxt.req = 1'b1;
         st_nxt.cnt = st_r.rr - 13'h0001;
      end else begin
         st_nxt.cnt = st_r.cnt - 13'h0001;
      end
      // writes land at the access edge, visible next cycle
      if (wr_en) begin
         if (hit_rrc) begin
            st_nxt.rr  = rr_new;
            // restart so the new period applies at once
            st_nxt.cnt = rr_new - 13'h0001;
         end
         if (hit_cfg) begin
            st_nxt.cfg[cfg_idx] = pwdata;
         end
         if (hit_tim) begin
            st_nxt.tim = pwdata & EMT_TIM_MASK;
         end
      end
      // read data captured in setup so prdata is a flop
      if (psel & ~penable) begin
         st_nxt.rdata = 32'h0000_0000;
         if (hit_rrc) begin
            st_nxt.rdata = {19'h0_0000, st_r.rr};
         end
         if (hit_cfg) begin
            st_nxt.rdata = st_r.cfg[cfg_idx];
         end
         if (hit_tim) begin
            st_nxt.rdata = st_r.tim;
         end
      end
   end

   // state register with constant reset values
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_r.rr    <= EMT_RR_RST;
         st_r.cfg   <= {EMT_NREG{EMT_CFG_RST}};
         st_r.tim   <= EMT_TIM_RST;
         st_r.cnt   <= EMT_RR_RST;
         st_r.req   <= 1'b0;
         st_r.rdata <= 32'h0000_0000;
      end else begin
         st_r <= st_nxt;
      end
   end

   // bus and refresh outputs
   assign prdata         = st_r.rdata;
   assign refresh_period = st_r.rr;
   assign refresh_req    = st_r.req;

   // sdram timing fields, straight from the register
   assign refresh_to_refresh_min    = st_r.tim[EMT_RFC_POS +: 5];
   assign precharge_min             = st_r.tim[EMT_RP_POS  +: 3];
   assign activate_to_access_min    = st_r.tim[EMT_RCD_POS +: 3];
   assign write_recovery_min        = st_r.tim[EMT_WR_POS  +: 3];
   assign activate_to_precharge_min = st_r.tim[EMT_RAS_POS +: 4];
   assign activate_to_activate_min  = st_r.tim[EMT_RC_POS  +: 4];
   assign bank_to_bank_activate_min = st_r.tim[EMT_RRD_POS +: 3];

   // per region field split; no shadowing, so a write is seen by
   // the very next transfer (controllers sample at access start)
   for (genvar g = 0; g < EMT_NREG; g++) begin : g_reg
      assign select_strobe_mode[g]   = st_r.cfg[g][EMT_SS_POS];
      // ew kept by software at 0 without a wait pin or in nand mode
      assign extended_wait_enable[g] = st_r.cfg[g][EMT_EW_POS];
      assign write_setup[g]          = st_r.cfg[g][EMT_WSU_POS +: 4];
      assign write_strobe[g]         = st_r.cfg[g][EMT_WST_POS +: 6];
      assign write_hold[g]           = st_r.cfg[g][EMT_WHO_POS +: 3];
      assign read_setup[g]           = st_r.cfg[g][EMT_RSU_POS +: 4];
      assign read_strobe[g]          = st_r.cfg[g][EMT_RST_POS +: 6];
      assign read_hold[g]            = st_r.cfg[g][EMT_RHO_POS +: 3];
      assign turnaround_min[g]       = st_r.cfg[g][EMT_TA_POS  +: 2];
      // codes 2 and 3 are reserved, passed on as written
      assign async_bus_width[g]      = st_r.cfg[g][EMT_AW_POS  +: 2];
   end

   // checks on the bank behaviour
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   a_rr_small_load: assert property (
      (wr_en && hit_rrc && pwdata[12:0] < EMT_RR_MIN)
      |=> refresh_period == 13'({$past(refresh_to_refresh_min), 1'b1}))
      else $error("small period not replaced by rfc minimum");

   a_rr_plain_load: assert property (
      (wr_en && hit_rrc && pwdata[12:0] >= EMT_RR_MIN)
      |=> refresh_period == $past(pwdata[12:0]))
      else $error("refresh period not stored");

   a_refresh_reload: assert property (
      (st_r.cnt == 13'h0000 && !(wr_en && hit_rrc))
      |=> refresh_req && st_r.cnt == $past(st_r.rr) - 13'h0001)
      else $error("refresh request or reload missing");

   a_refresh_gap: assert property (
      (refresh_req && refresh_period > 13'h0002 && !(wr_en && hit_rrc))
      |=> !refresh_req [*2])
      else $error("refresh requests too close");

   a_cfg_write: assert property (
      (wr_en && hit_cfg)
      |=> st_r.cfg[$past(cfg_idx)] == $past(pwdata))
      else $error("region config not updated");

   a_tim_write: assert property (
      (wr_en && hit_tim)
      |=> st_r.tim == ($past(pwdata) & EMT_TIM_MASK))
      else $error("timing register not updated");

   a_rsvd_zero: assert property (
      (acc && !pwrite && (hit_tim || hit_rrc))
      |-> (prdata & ~(hit_tim ? EMT_TIM_MASK : 32'h0000_1FFF)) == 32'h0000_0000)
      else $error("reserved bits read nonzero");

   a_unmapped_err: assert property (
      (acc && !mapped) |-> pslverr ##1 $stable(st_r.cfg) && $stable(st_r.tim))
      else $error("unmapped access not refused");

   a_read_match: assert property (
      (psel && !penable && !pwrite && hit_cfg)
      |=> prdata == st_r.cfg[$past(cfg_idx)])
      else $error("region read data wrong");

   // assertion notes:
   //   all checks run on sys_clk and are off in reset
   //   the bench is the apb master; these watch only
   //   what the bank drives or holds
   //   read checks look one cycle after setup, where
   //   the captured word stands for the access phase
   //   cover points mark the scenarios the bench
   //   is expected to reach: short period, refresh,
   //   select strobe write, unmapped access and a
   //   reserved width code

   // period read returns the field with zeros above
   a_rrc_read: assert property (
      (psel && !penable && !pwrite && hit_rrc)
      |=> prdata == {19'h0_0000, $past(refresh_period)})
      else $error("refresh period read data wrong");

   // timing read returns the stored word
   a_tim_read: assert property (
      (psel && !penable && !pwrite && hit_tim)
      |=> prdata == $past(st_r.tim))
      else $error("timing read data wrong");

   // unmapped read gives zero data
   a_unmapped_read: assert property (
      (psel && !penable && !mapped)
      |=> prdata == 32'h0000_0000)
      else $error("unmapped read data not zero");

   // a mapped access never errors
   a_mapped_ok: assert property (
      (acc && mapped) |-> !pslverr)
      else $error("mapped access refused");

   // counter never above the period it was loaded from
   a_cnt_range: assert property (
      st_r.cnt <= st_r.rr)
      else $error("refresh counter out of range");

   // reserved timing bits never stored
   a_tim_rsvd: assert property (
      (st_r.tim & ~EMT_TIM_MASK) == 32'h0000_0000)
      else $error("reserved timing bits stored");

   c_small_write: cover property (wr_en && hit_rrc && pwdata[12:0] < EMT_RR_MIN);
   c_refresh:     cover property (refresh_req);
   c_cfg_write:   cover property (wr_en && hit_cfg && pwdata[EMT_SS_POS]);
   c_unmapped:    cover property (pslverr);
   c_width_rsvd:  cover property (wr_en && hit_cfg && pwdata[1:0] == 2'b11);

endmodule : emt_config_regs

// File: hdl/emt_pkg.sv
// emt_pkg: map, field layout and reset values of the external memory
// timing configuration bank. assumes a 32-bit apb word per register.
package emt_pkg;
   // register byte offsets
   localparam logic [7:0] EMT_OFS_RRC  = 8'h00;
   localparam logic [7:0] EMT_OFS_CFG2 = 8'h04;
   localparam logic [7:0] EMT_OFS_CFG5 = 8'h10;
   localparam logic [7:0] EMT_OFS_TIM  = 8'h14;
   // refresh period field
   localparam int          EMT_RR_W     = 13;
   localparam logic [12:0] EMT_RR_RST   = 13'h04E2;
   localparam logic [12:0] EMT_RR_MIN   = 13'h0020;
   // async region config field lsbs
   localparam int EMT_SS_POS  = 31;
   localparam int EMT_EW_POS  = 30;
   localparam int EMT_WSU_POS = 26;
   localparam int EMT_WST_POS = 20;
   localparam int EMT_WHO_POS = 17;
   localparam int EMT_RSU_POS = 13;
   localparam int EMT_RST_POS = 7;
   localparam int EMT_RHO_POS = 4;
   localparam int EMT_TA_POS  = 2;
   localparam int EMT_AW_POS  = 0;
   localparam logic [31:0] EMT_CFG_RST = 32'h3FFF_FFFC;
   // sdram timing field lsbs
   localparam int EMT_RFC_POS = 27;
   localparam int EMT_RP_POS  = 24;
   localparam int EMT_RCD_POS = 20;
   localparam int EMT_WR_POS  = 16;
   localparam int EMT_RAS_POS = 12;
   localparam int EMT_RC_POS  = 8;
   localparam int EMT_RRD_POS = 4;
   localparam logic [31:0] EMT_TIM_RST  = 32'h4221_5810;
   localparam logic [31:0] EMT_TIM_MASK = 32'hFF77_FF70;
   // region count
   localparam int EMT_NREG = 4;
   // whole block state
   typedef struct packed {
      logic [12:0]       rr;
      logic [3:0][31:0]  cfg;
      logic [31:0]       tim;
      logic [12:0]       cnt;
      logic              req;
      logic [31:0]       rdata;
   } emt_state_t;
endpackage : emt_pkg

// File: verification/emt_mem_model.sv
// emt_mem_model: stand-in for the sdram controller on the far side of the
// bank; it times the spacing of refresh requests it receives.
// assumes refresh_req is a one-cycle pulse clocked by sys_clk.
`timescale 1ns/10ps
module emt_mem_model (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // refresh request from the bank
   input  wire logic        refresh_req,
   // measured spacing and running count
   output logic [15:0]      gap,
   output logic [15:0]      pulses
);
   logic [15:0] cnt_r;      // cycles since last request
   // a request closes one interval and opens the next
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_r  <= 16'h0001;
         gap    <= 16'h0000;
         pulses <= 16'h0000;
      end else if (refresh_req) begin
         gap    <= cnt_r;
         cnt_r  <= 16'h0001;
         pulses <= pulses + 16'h0001;
      end else begin
         cnt_r  <= cnt_r + 16'h0001;  // wraps only on very long periods
      end
   end
endmodule : emt_mem_model

// File: verification/tb_emt_config_regs.sv
// tb_emt_config_regs: directed apb tests of the timing configuration bank.
// assumes a zero-wait apb slave and the memory model on the refresh side.
`timescale 1ns/10ps
module tb_emt_config_regs;
   import emt_pkg::*;
   // field layouts at reset, built field by field
   localparam logic [31:0] CFG_R = {2'h0, 4'hF, 6'h3F, 3'h7, 4'hF, 6'h3F, 3'h7, 2'h3, 2'h0};
   localparam logic [31:0] TIM_R = {5'h08, 3'h2, 1'h0, 3'h2, 1'h0, 3'h1, 4'h5, 4'h8, 1'h0, 3'h1, 4'h0};
   logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, refresh_req;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [12:0] refresh_period;
   logic [4:0]  rfc;
   logic [2:0]  rp, rcd, wr, rrd;
   logic [3:0]  ras, rc, ss, ew;
   logic [3:0][3:0] wsu, rsu;
   logic [3:0][5:0] wst, rstb;
   logic [3:0][2:0] who, rho;
   logic [3:0][1:0] ta, aw;
   logic [15:0] gap, pulses;
   logic        er;
   int          fails, comparisons;
   emt_config_regs dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .refresh_period(refresh_period), .refresh_req(refresh_req), .refresh_to_refresh_min(rfc),
      .precharge_min(rp), .activate_to_access_min(rcd), .write_recovery_min(wr),
      .activate_to_precharge_min(ras), .activate_to_activate_min(rc), .bank_to_bank_activate_min(rrd),
      .select_strobe_mode(ss), .extended_wait_enable(ew), .write_setup(wsu), .write_strobe(wst),
      .write_hold(who), .read_setup(rsu), .read_strobe(rstb), .read_hold(rho), .turnaround_min(ta),
      .async_bus_width(aw));
   emt_mem_model mem_u (.sys_clk(sys_clk), .rst(rst), .refresh_req(refresh_req), .gap(gap), .pulses(pulses));
   // free-running 100 mhz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic conclude();
      if (fails == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one whole apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 20) begin fails++; conclude(); end
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
      chk({31'h0, er}, 32'h0000_0000);
   endtask : rdc
   // the 32 bits of one region's outputs in register order
   function automatic logic [31:0] cfg_out(input int i);
      return {ss[i], ew[i], wsu[i], wst[i], who[i], rsu[i], rstb[i], rho[i], ta[i], aw[i]};
   endfunction : cfg_out
   // values after reset on the bus, and at the region and timing outputs
   task automatic t_reset();
      rdc(8'h00, 32'h0000_04E2);
      for (int i = 0; i < 4; i++) begin
         rdc(EMT_OFS_CFG2 + 8'(4 * i), CFG_R);
         chk(cfg_out(i), CFG_R);
      end
      rdc(EMT_OFS_TIM, TIM_R);
      chk({rfc, rp, 1'h0, rcd, 1'h0, wr, ras, rc, 1'h0, rrd, 4'h0}, TIM_R);
   endtask : t_reset
   // distinct pattern per region covers every mode and width code
   task automatic t_regions();
      logic [31:0] d;
      for (int i = 0; i < 4; i++) begin
         // extended wait kept off: no wait pin modelled, any region may be nand
         d = 32'h1A5A_5A5A ^ {i[0], 29'h0, i[1:0]};
         apb(1'b1, EMT_OFS_CFG2 + 8'(4 * i), d);
      end
      for (int i = 0; i < 4; i++) begin
         d = 32'h1A5A_5A5A ^ {i[0], 29'h0, i[1:0]};
         rdc(EMT_OFS_CFG2 + 8'(4 * i), d);
         chk(cfg_out(i), d);
      end
   endtask : t_regions
   // reserved bits, and the small-period substitution at its boundary
   task automatic t_period();
      apb(1'b1, EMT_OFS_TIM, 32'hFFFF_FFFF);
      rdc(EMT_OFS_TIM, 32'hFF77_FF70);
      chk({27'h0, rfc}, 32'h0000_001F);
      apb(1'b1, 8'h00, 32'hFFFF_FFFF);
      rdc(8'h00, 32'h0000_1FFF);
      apb(1'b1, 8'h00, 32'h0000_001F);
      rdc(8'h00, 32'h0000_003F);
      apb(1'b1, 8'h00, 32'h0000_0020);
      rdc(8'h00, 32'h0000_0020);
   endtask : t_period
   // two requests, and the full interval between them, at the shortest direct period
   task automatic t_refresh();
      logic [15:0] p0;
      int          n;
      p0 = pulses;
      n = 0;
      while (pulses < p0 + 16'h0002 && n < 200) begin @(posedge sys_clk); n++; end
      if (n >= 200) begin fails++; conclude(); end
      chk({16'h0, gap}, 32'h0000_0020);
   endtask : t_refresh
   // unmapped word refuses and changes nothing
   task automatic t_unmapped();
      apb(1'b1, 8'h18, 32'hFFFF_FFFF);
      chk({31'h0, er}, 32'h0000_0001);
      apb(1'b0, 8'h18, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      rdc(8'h00, 32'h0000_0020);
   endtask : t_unmapped
   initial begin
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
      fails = 0; comparisons = 0;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_regions();
      t_period();
      t_refresh();
      t_unmapped();
      conclude();
   end
endmodule : tb_emt_config_regs
